// ### rtl/bcr_pkg.sv
// Package with register map constants and types for the bias control register bank.
package bcr_pkg;
    localparam logic [7:0] BCR_ADDR_TABLE_ONE_ROW = 8'h81;
    localparam logic [7:0] BCR_ADDR_TABLE_TWO_ROW = 8'h82;
    localparam logic [7:0] BCR_ADDR_CONV_ONE_CODE = 8'h83;
    localparam logic [7:0] BCR_ADDR_CONV_TWO_CODE = 8'h84;
    localparam logic [7:0] BCR_ADDR_DIRECT_CFG = 8'h85;
    localparam logic [7:0] BCR_ADDR_WRITE_ENABLE = 8'h86;
    localparam logic [7:0] BCR_ADDR_ADC_STATUS = 8'h87;
    localparam logic [7:0] BCR_ADDR_RSVD_LO = 8'h88;
    localparam logic [7:0] BCR_ADDR_RSVD_HI = 8'h8f;
    // Table addresses reach past FFh, since table two ends at 10Fh.
    typedef logic [8:0] bcr_table_addr_t;
    localparam bcr_table_addr_t BCR_TABLE_ONE_BASE = 9'h090;
    localparam bcr_table_addr_t BCR_TABLE_TWO_BASE = 9'h0d0;
    localparam logic [7:0] BCR_WEL_SET_PATTERN = 8'h80;
    localparam logic [7:0] BCR_WEL_CLR_PATTERN = 8'h00;
    localparam logic [7:0] BCR_RESET_BYTE = 8'h00;
    localparam logic [5:0] BCR_RESET_ROW = 6'h00;
    localparam logic [1:0] BCR_FS_EXTERNAL = 2'h0;
    localparam logic [1:0] BCR_FS_LOW = 2'h1;
    localparam logic [1:0] BCR_FS_MIDDLE = 2'h2;
    localparam logic [1:0] BCR_FS_HIGH = 2'h3;

    // Direct access configuration byte, bit 7 down to bit 0.
    typedef struct packed {
        logic converter_two_direct_sel;
        logic table_two_direct_sel;
        logic converter_one_direct_sel;
        logic table_one_direct_sel;
        logic [1:0] gen_two_fullscale_sel;
        logic [1:0] gen_one_fullscale_sel;
    } bcr_direct_cfg_t;

    // One-hot full-scale range decode.
    typedef struct packed {
        logic high;
        logic middle;
        logic low;
        logic external;
    } bcr_range_t;

    // Register access request from the serial front end.
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] data;
    } bcr_req_t;

    // Nonvolatile write strobe toward the storage cells.
    typedef struct packed {
        logic valid;
        logic [7:0] addr;
        logic [7:0] data;
    } bcr_nv_wr_t;
endpackage

// ### rtl/bcr_register_bank.sv
// Control and status register bank for the two table-driven current generators.
`timescale 1ns/1ns

// Operation
// RL1: Table one row register at 81h, six bits.
// RL2: Table two row register at 82h, six bits.
// RL3: Converter one direct code at 83h, eight bits.
// RL4: Converter two direct code at 84h, eight bits.
// RL5: 81h-84h volatility follows the volatility select bit.
// RL6: Direct access configuration register at 85h.
// RL7: Bit 4 selects row register for table one.
// RL8: Table one address is 90h plus row.
// RL9: Bit 6 selects row register for table two.
// RL10: Table two address is D0h plus row.
// RL11: Bit 5 feeds converter one from 83h code.
// RL12: Bit 7 feeds converter two from 84h code.
// RL13: Write enable latch is 86h bit 7.
// RL14: Addresses 88h to 8Fh hold no registers.
// RL15: Generator two sources at 0, sinks at 1.
// RL16: Latch resets clear; 80h sets, 00h clears.
// RL17: Latch clear aborts writes and withholds acknowledge; the code still accepts and acknowledges writes to 86h.
// RL18: Volatility bit one also stores to nonvolatile cells.
// RL19: Reserved bits written zero, ignored on read.
// RL20: Full-scale field decodes external, low, middle, high.
// RL21: ADC result in 87h bits 7 to 2.
module bcr_register_bank
    import bcr_pkg::*;
#(
    parameter int ROW_W = 6,
    parameter int CODE_W = 8
)
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire bcr_req_t req_i,
    input wire logic ctrl_nonvolatile_sel_i,
    input wire logic gen_two_direction_sel_i,
    input wire logic [ROW_W-1:0] adc_result_i,
    input wire logic [CODE_W-1:0] table_one_row_data_i,
    input wire logic [CODE_W-1:0] table_two_row_data_i,
    output logic [7:0] rd_data_o,
    output logic wr_ack_o,
    output bcr_nv_wr_t nv_wr_o,
    output bcr_table_addr_t table_one_addr_o,
    output bcr_table_addr_t table_two_addr_o,
    output logic [CODE_W-1:0] converter_one_o,
    output logic [CODE_W-1:0] converter_two_o,
    output bcr_range_t gen_one_range_o,
    output bcr_range_t gen_two_range_o,
    output logic gen_two_sink_o,
    output logic write_enable_latch_o
);

    logic [ROW_W-1:0] table_one_row_index_reg;
    logic [ROW_W-1:0] table_two_row_index_reg;
    logic [CODE_W-1:0] converter_one_code_reg;
    logic [CODE_W-1:0] converter_two_code_reg;
    bcr_direct_cfg_t direct_cfg_reg;
    logic write_enable_latch_reg;
    logic wr_ok;
    logic latch_wr;
    logic row_one_wr;
    logic row_two_wr;
    logic code_one_wr;
    logic code_two_wr;
    logic direct_cfg_wr;

    function automatic bcr_range_t decode_range(input logic [1:0] sel);
        bcr_range_t r;
        r = '0;
        case (sel)
            BCR_FS_EXTERNAL: r.external = 1'b1;
            BCR_FS_LOW: r.low = 1'b1;
            BCR_FS_MIDDLE: r.middle = 1'b1;
            default: r.high = 1'b1;
        endcase
        return r;
    endfunction

    // Picks out an accepted write aimed at one register address.
    function automatic logic write_hit(
        input logic ok,
        input logic [7:0] addr,
        input logic [7:0] target
    );
        return ok && addr == target;
    endfunction

    // Offsets a table base by the direct row or by the converter result.
    function automatic bcr_table_addr_t table_addr(
        input bcr_table_addr_t base,
        input logic direct_sel,
        input logic [ROW_W-1:0] row,
        input logic [ROW_W-1:0] adc
    );
        bcr_table_addr_t offset;
        offset = bcr_table_addr_t'(direct_sel ? row : adc);
        return base + offset;
    endfunction

    // Widens a row index to a byte whose reserved bits read as zero.
    function automatic logic [7:0] row_byte(input logic [ROW_W-1:0] row);
        return 8'(row);
    endfunction

    // Writes other than to the latch itself need the latch set.
    assign wr_ok = req_i.wr && write_enable_latch_reg; // see RL17

    // Register selects; the latch takes its own write even while clear.
    assign latch_wr = write_hit(req_i.wr, req_i.addr, BCR_ADDR_WRITE_ENABLE); // see RL13
    assign row_one_wr = write_hit(wr_ok, req_i.addr, BCR_ADDR_TABLE_ONE_ROW);
    assign row_two_wr = write_hit(wr_ok, req_i.addr, BCR_ADDR_TABLE_TWO_ROW);
    assign code_one_wr = write_hit(wr_ok, req_i.addr, BCR_ADDR_CONV_ONE_CODE);
    assign code_two_wr = write_hit(wr_ok, req_i.addr, BCR_ADDR_CONV_TWO_CODE);
    assign direct_cfg_wr = write_hit(wr_ok, req_i.addr, BCR_ADDR_DIRECT_CFG);

    // Acknowledge after the data byte only for accepted writes.
    always_comb
    begin
        wr_ack_o = 1'b0;
        if (req_i.wr)
        begin
            wr_ack_o = write_enable_latch_reg || latch_wr; // see RL17
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            write_enable_latch_reg <= 1'b0; // see RL16
        end
        else if (latch_wr)
        begin
            if (req_i.data == BCR_WEL_SET_PATTERN)
            begin
                write_enable_latch_reg <= 1'b1; // see RL16
            end
            else if (req_i.data == BCR_WEL_CLR_PATTERN)
            begin
                write_enable_latch_reg <= 1'b0; // see RL16
            end
        end
    end

    // Table one row index.
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            table_one_row_index_reg <= BCR_RESET_ROW;
        end
        else if (row_one_wr)
        begin
            table_one_row_index_reg <= req_i.data[ROW_W-1:0]; // see RL1
        end
    end

    // Table two row index.
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            table_two_row_index_reg <= BCR_RESET_ROW;
        end
        else if (row_two_wr)
        begin
            table_two_row_index_reg <= req_i.data[ROW_W-1:0]; // see RL2
        end
    end

    // Converter one direct code.
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            converter_one_code_reg <= BCR_RESET_BYTE;
        end
        else if (code_one_wr)
        begin
            converter_one_code_reg <= req_i.data; // see RL3
        end
    end

    // Converter two direct code.
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            converter_two_code_reg <= BCR_RESET_BYTE;
        end
        else if (code_two_wr)
        begin
            converter_two_code_reg <= req_i.data; // see RL4
        end
    end

    // Direct access configuration.
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            direct_cfg_reg <= '0;
        end
        else if (direct_cfg_wr)
        begin
            direct_cfg_reg <= bcr_direct_cfg_t'(req_i.data); // see RL6
        end
    end

    // Mirrors writes to 81h-84h into the nonvolatile cells when selected.
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            nv_wr_o <= '0;
        end
        else
        begin
            nv_wr_o.valid <= wr_ok && ctrl_nonvolatile_sel_i
                && req_i.addr >= BCR_ADDR_TABLE_ONE_ROW
                && req_i.addr <= BCR_ADDR_CONV_TWO_CODE; // see RL5 see RL18
            nv_wr_o.addr <= req_i.addr;
            nv_wr_o.data <= req_i.data;
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            rd_data_o <= BCR_RESET_BYTE;
        end
        else if (req_i.rd)
        begin
            case (req_i.addr)
                BCR_ADDR_TABLE_ONE_ROW: rd_data_o <= row_byte(table_one_row_index_reg); // see RL19
                BCR_ADDR_TABLE_TWO_ROW: rd_data_o <= row_byte(table_two_row_index_reg); // see RL19
                BCR_ADDR_CONV_ONE_CODE: rd_data_o <= converter_one_code_reg;
                BCR_ADDR_CONV_TWO_CODE: rd_data_o <= converter_two_code_reg;
                BCR_ADDR_DIRECT_CFG: rd_data_o <= direct_cfg_reg;
                BCR_ADDR_WRITE_ENABLE: rd_data_o <= {write_enable_latch_reg, 7'h00}; // see RL13
                BCR_ADDR_ADC_STATUS: rd_data_o <= {adc_result_i, 2'h0}; // see RL21
                default: rd_data_o <= BCR_RESET_BYTE; // see RL14
            endcase
        end
    end

    // Table addressing and converter feed.
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            table_one_addr_o <= BCR_TABLE_ONE_BASE;
        end
        else
        begin
            table_one_addr_o <= table_addr(BCR_TABLE_ONE_BASE, // see RL8
                direct_cfg_reg.table_one_direct_sel, // see RL7
                table_one_row_index_reg, adc_result_i);
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            table_two_addr_o <= BCR_TABLE_TWO_BASE;
        end
        else
        begin
            table_two_addr_o <= table_addr(BCR_TABLE_TWO_BASE, // see RL10
                direct_cfg_reg.table_two_direct_sel, // see RL9
                table_two_row_index_reg, adc_result_i);
        end
    end

    // Converters take the direct code or the addressed table row.
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            converter_one_o <= BCR_RESET_BYTE;
        end
        else if (direct_cfg_reg.converter_one_direct_sel)
        begin
            converter_one_o <= converter_one_code_reg; // see RL11
        end
        else
        begin
            converter_one_o <= table_one_row_data_i; // see RL11
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            converter_two_o <= BCR_RESET_BYTE;
        end
        else if (direct_cfg_reg.converter_two_direct_sel)
        begin
            converter_two_o <= converter_two_code_reg; // see RL12
        end
        else
        begin
            converter_two_o <= table_two_row_data_i; // see RL12
        end
    end

    // Full-scale range decode and generator two direction.
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            gen_one_range_o <= '0;
        end
        else
        begin
            gen_one_range_o <= decode_range(direct_cfg_reg.gen_one_fullscale_sel); // see RL20
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            gen_two_range_o <= '0;
        end
        else
        begin
            gen_two_range_o <= decode_range(direct_cfg_reg.gen_two_fullscale_sel); // see RL20
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            gen_two_sink_o <= 1'b0;
        end
        else
        begin
            gen_two_sink_o <= gen_two_direction_sel_i; // see RL15
        end
    end

    assign write_enable_latch_o = write_enable_latch_reg;

endmodule

// ### testbench/bcr_host.sv
// Host model that issues single-cycle register requests.
`timescale 1ns/1ns
module bcr_host
    import bcr_pkg::*;
(
    input wire logic clk_i,
    output bcr_req_t req_o
);
    initial req_o = '0;

    // Drives one request for one cycle, then turns the address and data lines round.
    task automatic put(input logic wr, input logic [7:0] addr, input logic [7:0] data);
        @(posedge clk_i);
        req_o <= '{wr, !wr, addr, data};
        @(posedge clk_i);
        req_o <= '{1'b0, 1'b0, ~addr, ~data};
    endtask
endmodule

// ### testbench/bcr_checker.sv
// Concurrent checks on the ports of the register bank.
`timescale 1ns/1ns
module bcr_checker
    import bcr_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire bcr_req_t req_i,
    input wire logic ctrl_nonvolatile_sel_i,
    input wire logic [5:0] adc_result_i,
    input wire logic [7:0] rd_data_o,
    input wire logic wr_ack_o,
    input wire bcr_nv_wr_t nv_wr_o,
    input wire bcr_table_addr_t table_one_addr_o,
    input wire bcr_table_addr_t table_two_addr_o,
    input wire bcr_range_t gen_one_range_o,
    input wire logic write_enable_latch_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    wire logic wr86 = req_i.wr && req_i.addr == 8'h86;
    wire logic row_wr = req_i.wr && req_i.addr >= 8'h81 && req_i.addr <= 8'h84;

    a_write_refused: assert property (req_i.wr && !write_enable_latch_o && !wr86
        |-> !wr_ack_o) else $error("write acknowledged while latch clear");
    a_write_acked: assert property (req_i.wr && (write_enable_latch_o || wr86)
        |-> wr_ack_o) else $error("accepted write not acknowledged");
    a_nv_copy: assert property (row_wr && wr_ack_o && ctrl_nonvolatile_sel_i
        |=> nv_wr_o.valid && nv_wr_o.addr == $past(req_i.addr)
        && nv_wr_o.data == $past(req_i.data)) else $error("no nv copy");
    a_nv_volatile: assert property (!ctrl_nonvolatile_sel_i |=> !nv_wr_o.valid)
        else $error("nv copy while volatile");
    a_range_onehot: assert property (!$past(rst_i) |-> $onehot(gen_one_range_o))
        else $error("range not one-hot");
    a_row_one: assert property ((table_one_addr_o - BCR_TABLE_ONE_BASE) < 9'h040)
        else $error("table one address outside table");
    a_row_two: assert property ((table_two_addr_o - BCR_TABLE_TWO_BASE) < 9'h040)
        else $error("table two address outside table");
    a_status_read: assert property (req_i.rd && req_i.addr == 8'h87
        |=> rd_data_o == {$past(adc_result_i), 2'h0}) else $error("bad status read");
    a_rsvd_read: assert property (req_i.rd && req_i.addr[7:3] == 5'h11
        |=> rd_data_o == 8'h00) else $error("reserved read not zero");
    a_latch_set: assert property (wr86 && req_i.data == 8'h80 |=> write_enable_latch_o)
        else $error("latch not set");

    cover property (wr86);
    cover property (row_wr && ctrl_nonvolatile_sel_i);
    cover property (req_i.rd && req_i.addr == 8'h87);
endmodule

bind bcr_register_bank bcr_checker bcr_checker_i (.clk_i, .rst_i, .req_i, .ctrl_nonvolatile_sel_i,
    .adc_result_i, .rd_data_o, .wr_ack_o, .nv_wr_o, .table_one_addr_o, .table_two_addr_o,
    .gen_one_range_o, .write_enable_latch_o);

// ### testbench/test_bcr_register_bank.sv
// Testbench for the bias control register bank.
`timescale 1ns/1ns
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin n_mismatch++; \
    $display("wrong value at %0t: %h expected %h", $time, a, e); end end
module test_bcr_register_bank
    import bcr_pkg::*;
;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    bcr_req_t req_i;
    logic ctrl_nonvolatile_sel_i = 1'b1;
    logic gen_two_direction_sel_i = 1'b1;
    logic [5:0] adc_result_i = 6'h2d;
    logic [7:0] table_one_row_data_i = 8'h3c;
    logic [7:0] table_two_row_data_i = 8'hc3;
    logic [7:0] rd_data_o, converter_one_o, converter_two_o;
    bcr_table_addr_t table_one_addr_o, table_two_addr_o;
    logic wr_ack_o, gen_two_sink_o, write_enable_latch_o;
    bcr_nv_wr_t nv_wr_o;
    bcr_range_t gen_one_range_o, gen_two_range_o;
    int n_mismatch = 0;
    int checked = 0;
    logic [23:0] rows [8] = '{24'h86_80_80, 24'h81_3f_3f, 24'h82_3f_3f, 24'h83_a5_a5,
        24'h84_5a_5a, 24'h85_f6_f6, 24'h8a_00_00, 24'h87_fc_b4};

    bcr_host bcr_host_i (.clk_i, .req_o(req_i));
    bcr_register_bank bcr_register_bank_i (.clk_i, .rst_i, .req_i, .ctrl_nonvolatile_sel_i,
        .gen_two_direction_sel_i, .adc_result_i, .table_one_row_data_i, .table_two_row_data_i,
        .rd_data_o, .wr_ack_o, .nv_wr_o, .table_one_addr_o, .table_two_addr_o, .converter_one_o,
        .converter_two_o, .gen_one_range_o, .gen_two_range_o, .gen_two_sink_o,
        .write_enable_latch_o);

    always #50 clk_i = ~clk_i;

    task automatic rd_cmp(input logic [7:0] a, input logic [7:0] e);
        bcr_host_i.put(1'b0, a, 8'h00);
        #1;
        `CHK(rd_data_o, e)
    endtask

    task automatic test_done();
        if (n_mismatch == 0 && checked > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    initial
    begin
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        #1;
        `CHK({write_enable_latch_o, table_one_addr_o, table_two_addr_o}, 19'h120d0)
        foreach (rows[i])
        begin
            bcr_host_i.put(1'b1, rows[i][23:16], rows[i][15:8]);
            rd_cmp(rows[i][23:16], rows[i][7:0]);
        end
        `CHK(table_one_addr_o, 9'h0cf)
        `CHK(table_two_addr_o, 9'h10f)
        `CHK({converter_one_o, converter_two_o}, 16'ha55a)
        `CHK({gen_two_range_o, gen_one_range_o, gen_two_sink_o}, 9'h049)
        @(posedge clk_i);
        ctrl_nonvolatile_sel_i <= 1'b0;
        gen_two_direction_sel_i <= 1'b0;
        bcr_host_i.put(1'b1, 8'h85, 8'h0c);
        repeat (2) @(posedge clk_i);
        #1;
        `CHK(table_one_addr_o, 9'h0bd)
        `CHK(table_two_addr_o, 9'h0fd)
        `CHK({converter_one_o, converter_two_o}, 16'h3cc3)
        `CHK({gen_two_range_o, gen_one_range_o, gen_two_sink_o}, 9'h102)
        bcr_host_i.put(1'b1, 8'h86, 8'h00);
        bcr_host_i.put(1'b1, 8'h83, 8'h11);
        rd_cmp(8'h83, 8'ha5);
        `CHK(write_enable_latch_o, 1'b0)
        test_done();
    end
endmodule
